//--- design/port_a_alternate_function_override.sv
// alternate function override logic for the eight-pin port a
// What this block does
// R1: pull-up follows override when enabled, else input, output one, no global disable.
// R2: value override replaces output bit as driven level when enabled.
// R3: input enable follows override value when enabled, else normal or sleep state.
// R4: external or capacitor reference forces pin zero pull-up and driver off.
// R5: software keeps comparator pins as inputs without pull-ups.
// R6: three-wire mode drives serial data on pin five; output bit keeps pull-up.
// R7: spi master forces pin five to input; slave follows its direction bit.
// R8: spi slave forces pin six to input; master follows its direction bit.
// R9: spi-forced inputs keep pull-up under the pin's output bit.
// R10: software sets pin six input before three-wire data input use.
// R11: timer compare outputs reach pins only with direction bit set; pin five also needs a wire-mode bit, pin six wire-mode high.
// R12: pin seven value override from timer zero compare b; others zero.
// R13: pin seven input path feeds timer one input capture.
// R14: pin six direction override from wire-mode high, hold or output bit.
// R15: pin six value override from wire-mode term or compare a.
// R16: pin five value override from both wire-mode bits or compare b.
// R17: pin four serial clock direction, value and toggle overrides.
// R18: pins four and six input forced on by start irq or pin-change.
// R19: analog input disable turns input off unless another term forces on.
// R20: pins three and four feed timer zero and timer one count inputs.
// R21: port a pins are sources 0-7, port b pins sources 8-11.
// R22: pin seven compare output comes from timer zero compare b.
`timescale 1ns/1ps
module port_a_alternate_function_override
   import port_a_override_pkg::*;
(
   input  wire logic            ref_clk_in,
   input  wire logic            sys_rst_in,
   input  wire logic            clk_en_in,
   input  wire port_regs_type   regs_in,
   input  wire periph_ctrl_type ctrl_in,
   input  wire logic            sleep_in,
   input  wire logic [7:0]      pad_level_in,
   input  wire logic [3:0]      port_b_input_in,
   output logic [7:0]           pin_out_out,
   output logic [7:0]           pin_oe_out,
   output logic [7:0]           pull_up_out,
   output logic [7:0]           input_enable_out,
   output logic [7:0]           pin_change_src0_out,
   output logic [3:0]           pin_change_src1_out,
   output logic                 timer0_count_in_out,
   output logic                 timer1_count_in_out,
   output logic                 timer1_capture_in_out,
   output logic                 three_wire_data_in_out,
   output logic                 three_wire_clock_out
);

   // ------------------------------------------------------------
   // override equations
   // ------------------------------------------------------------
   pin_override_type ovr [PIN_COUNT];
   pin_state_type    state [PIN_COUNT];
   logic             ext_reference;
   logic             pcint_on [PIN_COUNT];
   logic             wm_high_dir6;
   logic             wm_high_dir4;
   logic             wm_both;
   logic [7:0]       next_input;

   function automatic pin_override_type plain_override(input logic pc_on, input logic adc_off);
      pin_override_type o;
      o = '0;
      o.input_enable_override_enable = pc_on | adc_off;
      o.input_enable_override_value  = pc_on;
      return o;
   endfunction

   // start condition keeps the serial pins listening; returns {enable, value}
   function automatic logic [1:0] serial_input_enable(input logic start_on, input logic pc_on, input logic adc_off);
      return {start_on | pc_on | adc_off, start_on | pc_on};
   endfunction

   always_comb
   begin
      // [R4]
      ext_reference = ctrl_in.reference_select_low;
      wm_high_dir6  = ctrl_in.serial_wire_mode_high & regs_in.direction[PIN_DATA_IN];
      wm_high_dir4  = ctrl_in.serial_wire_mode_high & regs_in.direction[PIN_CLOCK];
      wm_both       = ctrl_in.serial_wire_mode_high & ctrl_in.serial_wire_mode_low;
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         pcint_on[i] = ctrl_in.pin_change_mask[i] & ctrl_in.pin_change_group0_enable;
         // [R19]
         ovr[i] = plain_override(pcint_on[i], ctrl_in.analog_input_disable[i]);
      end

      // ------------------------------------------------------------
      // reference pin
      // ------------------------------------------------------------
      // [R4]
      ovr[PIN_REF].pull_up_override_enable   = ext_reference;
      ovr[PIN_REF].direction_override_enable = ext_reference;
      ovr[PIN_REF].value_override_enable     = ext_reference;

      // ------------------------------------------------------------
      // serial clock pin
      // ------------------------------------------------------------
      // [R17]
      ovr[PIN_CLOCK].direction_override_enable = ctrl_in.serial_wire_mode_high;
      ovr[PIN_CLOCK].direction_override_value  = (ctrl_in.serial_clock_hold | regs_in.output_bits[PIN_CLOCK])
                                                 & regs_in.direction[PIN_CLOCK];
      ovr[PIN_CLOCK].value_override_enable     = wm_high_dir4;
      ovr[PIN_CLOCK].value_override_value      = 1'h0;
      ovr[PIN_CLOCK].toggle_override_enable    = ctrl_in.serial_clock_toggle_strobe;
      // [R18]
      {ovr[PIN_CLOCK].input_enable_override_enable, ovr[PIN_CLOCK].input_enable_override_value}
         = serial_input_enable(ctrl_in.serial_start_irq_enable, pcint_on[PIN_CLOCK],
                               ctrl_in.analog_input_disable[PIN_CLOCK]);

      // ------------------------------------------------------------
      // serial data out pin
      // ------------------------------------------------------------
      // [R16] [R6] [R11]
      ovr[PIN_DATA_OUT].value_override_enable = wm_both | ctrl_in.timer1_compare_b_enable;
      ovr[PIN_DATA_OUT].value_override_value  = (wm_both & ctrl_in.serial_data_out)
         | ((ctrl_in.serial_wire_mode_high | ctrl_in.serial_wire_mode_low) & ctrl_in.timer1_compare_b_out);
      // [R7] [R9]
      ovr[PIN_DATA_OUT].direction_override_enable = ctrl_in.spi_enable & ctrl_in.spi_master;
      ovr[PIN_DATA_OUT].direction_override_value  = 1'h0;

      // ------------------------------------------------------------
      // serial data in pin
      // ------------------------------------------------------------
      // [R14]
      ovr[PIN_DATA_IN].direction_override_enable = ctrl_in.serial_wire_mode_high;
      ovr[PIN_DATA_IN].direction_override_value  = (ctrl_in.serial_data_hold | regs_in.output_bits[PIN_DATA_IN])
                                                   & regs_in.direction[PIN_DATA_IN];
      // [R8] [R9]
      if (ctrl_in.spi_enable & !ctrl_in.spi_master)
      begin
         ovr[PIN_DATA_IN].direction_override_enable = 1'h1;
         ovr[PIN_DATA_IN].direction_override_value  = 1'h0;
      end
      // [R15] [R11]
      ovr[PIN_DATA_IN].value_override_enable = wm_high_dir6 | ctrl_in.timer1_compare_a_enable;
      ovr[PIN_DATA_IN].value_override_value  = wm_high_dir6 & ctrl_in.timer1_compare_a_out;
      // [R18]
      {ovr[PIN_DATA_IN].input_enable_override_enable, ovr[PIN_DATA_IN].input_enable_override_value}
         = serial_input_enable(ctrl_in.serial_start_irq_enable, pcint_on[PIN_DATA_IN],
                               ctrl_in.analog_input_disable[PIN_DATA_IN]);

      // ------------------------------------------------------------
      // capture pin
      // ------------------------------------------------------------
      // [R12] [R22]
      ovr[PIN_CAPTURE].value_override_enable = ctrl_in.timer0_compare_b_enable;
      ovr[PIN_CAPTURE].value_override_value  = ctrl_in.timer0_compare_b_out;
   end

   // ------------------------------------------------------------
   // per-pin resolution
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++)
      begin : gen_pin
         pin_override_cell u_cell (
            .direction_in       (regs_in.direction[g]),
            .output_bit_in      (regs_in.output_bits[g]),
            .pull_up_disable_in (regs_in.pull_up_disable),
            .sleep_in           (sleep_in),
            .ovr_in             (ovr[g]),
            .state_out          (state[g])
         );
         assign next_input[g] = pad_level_in[g] & state[g].input_enable;
      end
   endgenerate

   // ------------------------------------------------------------
   // pad control registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         pin_out_out      <= RESET_BYTE;
         pin_oe_out       <= RESET_BYTE;
         pull_up_out      <= RESET_BYTE;
         input_enable_out <= RESET_BYTE;
      end
      else if (clk_en_in)
      begin
         for (int i = 0; i < PIN_COUNT; i++)
         begin
            pin_out_out[i]      <= state[i].drive_level;
            pin_oe_out[i]       <= state[i].drive_enable;
            pull_up_out[i]      <= state[i].pull_up;
            input_enable_out[i] <= state[i].input_enable;
         end
      end
   end

   // ------------------------------------------------------------
   // digital input distribution
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         pin_change_src0_out    <= RESET_BYTE;
         pin_change_src1_out    <= RESET_NIBBLE;
         timer0_count_in_out    <= 1'h0;
         timer1_count_in_out    <= 1'h0;
         timer1_capture_in_out  <= 1'h0;
         three_wire_data_in_out <= 1'h0;
         three_wire_clock_out   <= 1'h0;
      end
      else if (clk_en_in)
      begin
         pin_change_src0_out    <= next_input;                   // [R21]
         pin_change_src1_out    <= port_b_input_in;              // [R21]
         timer0_count_in_out    <= next_input[PIN_T0];           // [R20]
         timer1_count_in_out    <= next_input[PIN_CLOCK];        // [R20]
         timer1_capture_in_out  <= next_input[PIN_CAPTURE];      // [R13]
         three_wire_data_in_out <= next_input[PIN_DATA_IN];      // [R10]
         three_wire_clock_out   <= next_input[PIN_CLOCK];
      end
   end

endmodule

//--- design/port_a_override_pkg.sv
// constants and carrier types for the port a pin override block
package port_a_override_pkg;

   localparam int PIN_COUNT        = 8;
   localparam int GROUP1_PIN_COUNT = 4;
   // pin positions within port a
   localparam int PIN_REF          = 0;
   localparam int PIN_CMP_POS      = 1;
   localparam int PIN_CMP_NEG      = 2;
   localparam int PIN_T0           = 3;
   localparam int PIN_CLOCK        = 4;
   localparam int PIN_DATA_OUT     = 5;
   localparam int PIN_DATA_IN      = 6;
   localparam int PIN_CAPTURE      = 7;
   // pull-up enable pattern {direction, output, pull-up disable}
   localparam logic [2:0] PULL_UP_PATTERN = 3'h2;
   // reset values
   localparam logic [7:0] RESET_BYTE  = 8'h00;
   localparam logic [3:0] RESET_NIBBLE = 4'h0;

   // override set for one pin
   typedef struct packed {
      logic pull_up_override_enable;
      logic pull_up_override_value;
      logic direction_override_enable;
      logic direction_override_value;
      logic value_override_enable;
      logic value_override_value;
      logic toggle_override_enable;
      logic input_enable_override_enable;
      logic input_enable_override_value;
   } pin_override_type;

   // port register bits from the cpu side
   typedef struct packed {
      logic [7:0] direction;
      logic [7:0] output_bits;
      logic       pull_up_disable;
   } port_regs_type;

   // peripheral controls feeding the overrides
   typedef struct packed {
      logic       serial_wire_mode_high;
      logic       serial_wire_mode_low;
      logic       serial_start_irq_enable;
      logic       serial_clock_hold;
      logic       serial_clock_toggle_strobe;
      logic       serial_data_hold;
      logic       serial_data_out;
      logic       spi_enable;
      logic       spi_master;
      logic       reference_select_high;
      logic       reference_select_low;
      logic       timer0_compare_b_enable;
      logic       timer0_compare_b_out;
      logic       timer1_compare_a_enable;
      logic       timer1_compare_a_out;
      logic       timer1_compare_b_enable;
      logic       timer1_compare_b_out;
      logic       pin_change_group0_enable;
      logic [7:0] pin_change_mask;
      logic [7:0] analog_input_disable;
   } periph_ctrl_type;

   // resolved state of one pin
   typedef struct packed {
      logic pull_up;
      logic drive_enable;
      logic drive_level;
      logic input_enable;
   } pin_state_type;

endpackage

//--- design/pin_override_cell.sv
// generic override resolution for one port pin
`timescale 1ns/1ps
module pin_override_cell
   import port_a_override_pkg::*;
(
   input  wire logic             direction_in,
   input  wire logic             output_bit_in,
   input  wire logic             pull_up_disable_in,
   input  wire logic             sleep_in,
   input  wire pin_override_type ovr_in,
   output pin_state_type         state_out
);

   always_comb
   begin
      // [R1]
      if (ovr_in.pull_up_override_enable)
      begin
         state_out.pull_up = ovr_in.pull_up_override_value;
      end
      else
      begin
         state_out.pull_up = ({direction_in, output_bit_in, pull_up_disable_in} == PULL_UP_PATTERN);
      end
      state_out.drive_enable = ovr_in.direction_override_enable ? ovr_in.direction_override_value
                                                                : direction_in;
      // [R2]
      if (ovr_in.value_override_enable)
      begin
         state_out.drive_level = ovr_in.value_override_value;
      end
      else
      begin
         state_out.drive_level = output_bit_in ^ ovr_in.toggle_override_enable;
      end
      // [R3]
      state_out.input_enable = ovr_in.input_enable_override_enable ? ovr_in.input_enable_override_value
                                                                   : !sleep_in;
   end

endmodule

//--- sim/port_a_override_checker.sv
// assertions for the port a override block
`timescale 1ns/1ps
module port_a_override_checker
   import port_a_override_pkg::*;
(
   input wire logic            ref_clk_in,
   input wire logic            sys_rst_in,
   input wire logic            clk_en_in,
   input wire port_regs_type   regs_in,
   input wire periph_ctrl_type ctrl_in,
   input wire logic [7:0]      pad_level_in,
   input wire logic [7:0]      pin_out_out,
   input wire logic [7:0]      pin_oe_out,
   input wire logic [7:0]      pull_up_out,
   input wire logic [7:0]      input_enable_out,
   input wire logic            timer1_capture_in_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   chk_pull_up_plain: assert property (clk_en_in |=> pull_up_out[2] == (!$past(regs_in.direction[2]) &&
      $past(regs_in.output_bits[2]) && !$past(regs_in.pull_up_disable))) else $error("pin 2 pull-up wrong");
   chk_ref_pin_off: assert property (clk_en_in && ctrl_in.reference_select_low |=>
      !pull_up_out[0] && !pin_oe_out[0]) else $error("pin 0 not released");
   chk_pin7_compare: assert property (clk_en_in && ctrl_in.timer0_compare_b_enable |=>
      pin_out_out[7] == $past(ctrl_in.timer0_compare_b_out) && pin_oe_out[7] == $past(regs_in.direction[7]))
      else $error("pin 7 compare wrong");
   chk_spi_master_in: assert property (clk_en_in && ctrl_in.spi_enable && ctrl_in.spi_master |=>
      !pin_oe_out[5]) else $error("pin 5 driven as master");
   chk_spi_slave_in: assert property (clk_en_in && ctrl_in.spi_enable && !ctrl_in.spi_master |=>
      !pin_oe_out[6]) else $error("pin 6 driven as slave");
   chk_wire_data_out: assert property (clk_en_in && ctrl_in.serial_wire_mode_high && ctrl_in.serial_wire_mode_low |=>
      pin_out_out[5] == ($past(ctrl_in.serial_data_out) || $past(ctrl_in.timer1_compare_b_out)))
      else $error("pin 5 data wrong");
   chk_pin6_level: assert property (clk_en_in && ctrl_in.timer1_compare_a_enable |=> pin_out_out[6] ==
      ($past(ctrl_in.serial_wire_mode_high) && $past(regs_in.direction[6]) && $past(ctrl_in.timer1_compare_a_out)))
      else $error("pin 6 level wrong");
   chk_start_force: assert property (clk_en_in && ctrl_in.serial_start_irq_enable |=>
      input_enable_out[4] && input_enable_out[6]) else $error("start input not forced");
   chk_capture_path: assert property (clk_en_in |=>
      timer1_capture_in_out == ($past(pad_level_in[7]) && input_enable_out[7])) else $error("capture path wrong");
endmodule

bind port_a_alternate_function_override port_a_override_checker i_port_a_override_checker (
   .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .regs_in(regs_in),
   .ctrl_in(ctrl_in), .pad_level_in(pad_level_in), .pin_out_out(pin_out_out), .pin_oe_out(pin_oe_out),
   .pull_up_out(pull_up_out), .input_enable_out(input_enable_out), .timer1_capture_in_out(timer1_capture_in_out));

//--- sim/periph_model.sv
// peripheral side model feeding the override controls
`timescale 1ns/1ps
module periph_model
   import port_a_override_pkg::*;
(
   input  wire logic            ref_clk_in,
   input  wire periph_ctrl_type cmd_in,
   output periph_ctrl_type      ctrl_out
);
   // controls move just after the edge, as a real peripheral register would
   always_ff @(posedge ref_clk_in)
   begin
      ctrl_out <= cmd_in;
   end
endmodule

//--- sim/port_a_alternate_function_override_tb.sv
// self-checking bench for the port a override block
`timescale 1ns/1ps
module port_a_alternate_function_override_tb import port_a_override_pkg::*;;
   logic            ref_clk_in;
   logic            sys_rst_in;
   logic            clk_en_in;
   logic            sleep_in;
   logic [7:0]      pads;
   logic [3:0]      port_b;
   port_regs_type   rg;
   periph_ctrl_type pc;
   periph_ctrl_type ctrl;
   logic [7:0]      pin_out, pin_oe, pull_up, in_en, src0;
   logic [3:0]      src1;
   logic            t0c, t1c, cap, twd, twc;
   int              errors = 0;
   int              cmp_count = 0;
   int              cyc = 0;

   periph_model i_periph_model (.ref_clk_in(ref_clk_in), .cmd_in(pc), .ctrl_out(ctrl));
   port_a_alternate_function_override i_port_a_alternate_function_override (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .regs_in(rg), .ctrl_in(ctrl),
      .sleep_in(sleep_in), .pad_level_in(pads), .port_b_input_in(port_b), .pin_out_out(pin_out),
      .pin_oe_out(pin_oe), .pull_up_out(pull_up), .input_enable_out(in_en), .pin_change_src0_out(src0),
      .pin_change_src1_out(src1), .timer0_count_in_out(t0c), .timer1_count_in_out(t1c),
      .timer1_capture_in_out(cap), .three_wire_data_in_out(twd), .three_wire_clock_out(twc));

   initial
   begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   task automatic close_out();
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // partner latches at one edge, design samples at the next
   task automatic go();
      repeat (2) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
   endtask

   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         errors++;
         close_out();
      end
   end

   initial
   begin
      sys_rst_in = 1'b1;
      clk_en_in = 1'b1;
      sleep_in = 1'b0;
      pads = 8'h00;
      port_b = 4'h0;
      rg = '0;
      pc = '0;
      repeat (8) @(negedge ref_clk_in);
      chk("oe_reset", 8'h00, pin_oe);
      sys_rst_in = 1'b0;
      rg.output_bits = 8'hFF;
      go(); chk("pull_up", 8'hFF, pull_up);
      rg.pull_up_disable = 1'b1;
      go(); chk("pull_up_pud", 8'h00, pull_up);
      rg = '{direction: 8'hFF, output_bits: 8'hFF, pull_up_disable: 1'b0};
      pc.reference_select_low = 1'b1;
      go(); chk("ref_oe", 8'hFE, pin_oe);
      chk("ref_out", 8'hFE, pin_out);
      rg.direction = 8'h00;
      go(); chk("ref_pu", 8'hFE, pull_up);
      pc = '0;
      rg = '{direction: 8'h80, output_bits: 8'h00, pull_up_disable: 1'b0};
      pc.timer0_compare_b_enable = 1'b1;
      pc.timer0_compare_b_out = 1'b1;
      go(); chk("cmp7_out", 8'h80, pin_out);
      rg.direction = 8'h00;
      go(); chk("cmp7_oe", 8'h00, pin_oe);
      pc = '0;
      rg.direction = 8'h60;
      pc.spi_enable = 1'b1;
      pc.spi_master = 1'b1;
      go(); chk("spi_master", 8'h40, pin_oe);
      pc.spi_master = 1'b0;
      go(); chk("spi_slave", 8'h20, pin_oe);
      rg = '{direction: 8'h00, output_bits: 8'h60, pull_up_disable: 1'b0};
      go(); chk("spi_pu", 8'h60, pull_up);
      pc = '0;
      rg = '{direction: 8'h20, output_bits: 8'h00, pull_up_disable: 1'b0};
      pc.serial_wire_mode_high = 1'b1;
      pc.serial_wire_mode_low = 1'b1;
      pc.serial_data_out = 1'b1;
      go(); chk("wire_do", 8'h20, pin_out);
      rg = '{direction: 8'h00, output_bits: 8'h20, pull_up_disable: 1'b0};
      go(); chk("wire_pu", 8'h20, pull_up);
      pc = '0;
      rg.direction = 8'h20;
      pc.timer1_compare_b_enable = 1'b1;
      pc.timer1_compare_b_out = 1'b1;
      go(); chk("cmpb_gated", 8'h00, pin_out);
      pc.serial_wire_mode_low = 1'b1;
      go(); chk("cmpb_pass", 8'h20, pin_out);
      pc = '0;
      rg = '{direction: 8'h40, output_bits: 8'h00, pull_up_disable: 1'b0};
      pc.serial_wire_mode_high = 1'b1;
      go(); chk("sda_release", 8'h00, pin_oe);
      pc.serial_data_hold = 1'b1;
      pc.timer1_compare_a_enable = 1'b1;
      pc.timer1_compare_a_out = 1'b1;
      go(); chk("sda_hold", 8'h40, pin_oe);
      chk("cmpa_out", 8'h40, pin_out);
      pc.serial_wire_mode_high = 1'b0;
      go(); chk("cmpa_gated", 8'h00, pin_out);
      pc = '0;
      rg = '{direction: 8'h10, output_bits: 8'h10, pull_up_disable: 1'b0};
      pc.serial_wire_mode_high = 1'b1;
      go(); chk("scl_oe", 8'h10, pin_oe);
      chk("scl_low", 8'h00, pin_out);
      rg.output_bits = 8'h00;
      pc.serial_clock_hold = 1'h1;
      go(); chk("scl_hold", 8'h10, pin_oe);
      pc.serial_wire_mode_high = 1'b0;
      pc.serial_clock_toggle_strobe = 1'b1;
      rg.output_bits = 8'h00;
      go(); chk("scl_toggle", 8'h10, pin_out);
      pc = '0;
      rg = '0;
      pads = 8'hFF;
      sleep_in = 1'b1;
      go(); chk("sleep_ie", 8'h00, in_en);
      chk("cmp_pins", 8'h00, {4'h0, pull_up[2:1], pin_oe[2:1]});
      pc.serial_start_irq_enable = 1'b1;
      go(); chk("start_ie", 8'h50, in_en);
      chk("start_paths", 8'h1A, {3'h0, twc, twd, t0c, t1c, cap});
      pc.serial_start_irq_enable = 1'b0;
      pc.pin_change_mask = 8'h88;
      pc.pin_change_group0_enable = 1'b1;
      go(); chk("pc_ie", 8'h88, in_en);
      chk("pc_paths", 8'h05, {3'h0, twc, twd, t0c, t1c, cap});
      chk("pc_src0", 8'h88, src0);
      sleep_in = 1'b0;
      pc.analog_input_disable = 8'hFF;
      pc.pin_change_mask = 8'h08;
      port_b = 4'hA;
      go(); chk("adc_off", 8'h08, in_en);
      chk("pc_src1", 8'h0A, {4'h0, src1});
      clk_en_in = 1'b0;
      pc.analog_input_disable = 8'h00;
      go(); chk("frozen", 8'h08, in_en);
      close_out();
   end
endmodule
